// ==== pld_pkg.sv ====
// constants and types shared by the lock detector files
// ****************************************************
// Notes on behaviour
// - tolerance is one or four reference cycles
// - each channel keeps last three lock results
// - status equals majority of three results
// - two good results needed to report lock
// - status bits presented for the status register
// - status bit interrupts only when mask enabled
// - phase tolerance only, no frequency check
// - two independent detectors, separate status
// - locked to unlocked transition is an event
// - summary flag not cleared by status read
// ****************************************************
package pld_pkg;
  localparam int PLD_CHANNELS = 2;
  localparam int PLD_TOL_FINE = 1;
  localparam int PLD_TOL_WIDE = 4;
  localparam int PLD_CNT_W = 4;
  localparam logic [2:0] PLD_HIST_RST = 3'h0;
  localparam logic [7:0] PLD_STAT_ADDR = 8'hB4;
  localparam int PLD_STAT_LOCK1_BIT = 0;
  localparam int PLD_STAT_LOCK2_BIT = 1;
  typedef enum logic [1:0] {
    PLD_IDLE,
    PLD_REF_FIRST,
    PLD_FB_FIRST
  } pld_state_e;
endpackage

// ==== pld_channel.sv ====
// one channel: phase window measurement and three-deep vote
`timescale 1ns/100ps
module pld_channel
  import pld_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // synchronised phase edges, one-cycle pulses
  input  wire logic i_ref_edge,
  input  wire logic i_fb_edge,
  input  wire logic i_tol_wide,
  // result
  output logic      o_lock,
  output logic      o_lost
);
  pld_state_e           state;
  logic [PLD_CNT_W-1:0] gap;
  logic [2:0]           hist;
  logic                 meas_done;
  logic                 meas_ok;
  logic [PLD_CNT_W-1:0] limit;

  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // tolerance counts undivided reference clock cycles
  assign limit = i_tol_wide ? PLD_CNT_W'(PLD_TOL_WIDE)
                            : PLD_CNT_W'(PLD_TOL_FINE);

  // ****************************************************
  // phase error measurement
  // ****************************************************
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state     <= PLD_IDLE;
      gap       <= '0;
      meas_done <= 1'b0;
      meas_ok   <= 1'b0;
    end else begin
      meas_done <= 1'b0;
      case (state)
        PLD_IDLE: begin
          gap <= '0;
          if (i_ref_edge && i_fb_edge) begin
            meas_done <= 1'b1;
            meas_ok   <= 1'b1;
          end else if (i_ref_edge) begin
            state <= PLD_REF_FIRST;
          end else if (i_fb_edge) begin
            state <= PLD_FB_FIRST;
          end
        end
        PLD_REF_FIRST, PLD_FB_FIRST: begin
          // saturate so a lost edge cannot wrap into a good result
          if (gap != '1) begin
            gap <= gap + PLD_CNT_W'(1);
          end
          if ((state == PLD_REF_FIRST && i_fb_edge) ||
              (state == PLD_FB_FIRST && i_ref_edge)) begin
            meas_done <= 1'b1;
            meas_ok   <= (gap < limit);
            state     <= PLD_IDLE;
          end
        end
        default: begin
          state <= PLD_IDLE;
        end
      endcase
    end
  end

  // ****************************************************
  // history and vote
  // ****************************************************
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hist <= PLD_HIST_RST;
    end else if (meas_done) begin
      hist <= {hist[1:0], meas_ok};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_lock <= 1'b0;
      o_lost <= 1'b0;
    end else begin
      o_lock <= maj3(hist);
      o_lost <= o_lock & ~maj3(hist);
    end
  end

  hist_vote_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    1'b1 |=> o_lock == maj3($past(hist)))
    else $error("lock status differs from vote");
  // the newest result must be good and one older one must agree
  two_good_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_lock) |-> $past(hist[0]) &&
      ($past(hist[1]) || $past(hist[2])))
    else $error("lock reported without two good results");
  lost_event_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $fell(o_lock) |-> o_lost)
    else $error("loss of lock without event");
  hist_shift_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    meas_done |=> hist[0] == $past(meas_ok))
    else $error("result not shifted into history");
  hist_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !meas_done |=> $stable(hist))
    else $error("history moved without measurement");
endmodule

// ==== pld_top.sv ====
// lock detector for two synthesiser loops
`timescale 1ns/100ps
module pld_top
  import pld_pkg::*;
#(
  parameter int CHANNELS = PLD_CHANNELS
)(
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst_b,
  // phase comparator inputs, asynchronous levels
  input  wire logic [CHANNELS-1:0] i_ref_div,
  input  wire logic [CHANNELS-1:0] i_fb_div,
  // control
  input  wire logic                i_tol_wide,
  input  wire logic [CHANNELS-1:0] i_irq_mask,
  input  wire logic                i_stat_read,
  // status
  output logic      [CHANNELS-1:0] o_lock,
  output logic      [CHANNELS-1:0] o_lost_flag,
  output logic                     o_summary,
  output logic                     o_irq
);
  logic [CHANNELS-1:0] ref_s1, ref_s2, ref_s3;
  logic [CHANNELS-1:0] fb_s1, fb_s2, fb_s3;
  logic [CHANNELS-1:0] lock_c, lost_c;
  logic                tol_s1, tol_s2;

  // ****************************************************
  // input synchronisers
  // ****************************************************
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ref_s1 <= '0;
      ref_s2 <= '0;
      ref_s3 <= '0;
      fb_s1  <= '0;
      fb_s2  <= '0;
      fb_s3  <= '0;
      tol_s1 <= 1'b0;
      tol_s2 <= 1'b0;
    end else begin
      ref_s1 <= i_ref_div;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      fb_s1  <= i_fb_div;
      fb_s2  <= fb_s1;
      fb_s3  <= fb_s2;
      tol_s1 <= i_tol_wide;
      tol_s2 <= tol_s1;
    end
  end

  // ****************************************************
  // channels
  // ****************************************************
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    pld_channel u_ch (
      .i_clk      (i_clk),
      .i_rst_b    (i_rst_b),
      .i_ref_edge (ref_s2[c] & ~ref_s3[c]),
      .i_fb_edge  (fb_s2[c] & ~fb_s3[c]),
      .i_tol_wide (tol_s2),
      .o_lock     (lock_c[c]),
      .o_lost     (lost_c[c])
    );
  end

  // ****************************************************
  // status and interrupt
  // ****************************************************
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_lock <= '0;
    end else begin
      o_lock <= lock_c;
    end
  end

  // loss flags: sticky until reset; status read does not clear them
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_lost_flag <= '0;
    end else begin
      o_lost_flag <= o_lost_flag | lost_c;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_summary <= 1'b0;
      o_irq     <= 1'b0;
    end else begin
      o_summary <= |(o_lost_flag | lost_c);
      o_irq     <= |((o_lost_flag | lost_c) & i_irq_mask);
    end
  end

  irq_mask_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_irq |-> |($past(o_lost_flag | lost_c) & $past(i_irq_mask)))
    else $error("interrupt raised while masked");
  summary_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_summary && i_stat_read |=> o_summary)
    else $error("summary cleared by status read");
  flag_sticky_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    |lost_c |=> |o_lost_flag)
    else $error("loss event not captured");
endmodule

// ==== pld_loop_model.sv ====
// behavioural loop model driving divided phase edges
`timescale 1ns/100ps
module pld_loop_model #(
  parameter int PERIOD = 40
)(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // fb lag behind ref, in clocks
  input  wire logic [3:0] i_gap,
  // divided phases
  output logic            o_ref,
  output logic            o_fb
);
  int         cnt;
  logic [3:0] gap;
  // lag taken once a period so one hold gives one measurement
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 0;
      gap <= 4'h0;
    end else begin
      cnt <= (cnt + 1) % PERIOD;
      if (cnt == PERIOD - 1) begin
        gap <= i_gap;
      end
    end
  end
  assign o_ref = cnt >= PERIOD / 2;
  assign o_fb  = ((cnt - int'(gap) + PERIOD) % PERIOD) >= PERIOD / 2;
endmodule

// ==== pld_tb.sv ====
// self-checking bench for the two-channel lock detector
`timescale 1ns/100ps
module testbench;
  logic            i_clk;
  logic            i_rst_b;
  // each bit comes from its own loop model, so these stay nets
  wire logic [1:0] ref_div;
  wire logic [1:0] fb_div;
  logic      [1:0] mask;
  logic      [1:0] lock;
  logic      [1:0] lost;
  logic            wide;
  logic            rd;
  logic            summary;
  logic            irq;
  logic      [3:0] gap0;
  logic      [3:0] gap1;
  int              err_total;
  int              n_tests;
  int              cycles;
  pld_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ref_div(ref_div),
    .i_fb_div(fb_div), .i_tol_wide(wide), .i_irq_mask(mask),
    .i_stat_read(rd), .o_lock(lock), .o_lost_flag(lost),
    .o_summary(summary), .o_irq(irq));
  pld_loop_model lp0 (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_gap(gap0),
    .o_ref(ref_div[0]), .o_fb(fb_div[0]));
  pld_loop_model lp1 (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_gap(gap1),
    .o_ref(ref_div[1]), .o_fb(fb_div[1]));
  // ****************************************************
  // helpers
  // ****************************************************
  task automatic wait_chk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [1:0] e,
                     input logic [1:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_acquire();
    wait_chk(45);
    chk("lock", 2'b00, lock);
    wait_chk(45);
    chk("lock", 2'b01, lock);
    $display("acquire finished");
  endtask
  task automatic t_tol();
    @(posedge i_clk);
    gap1 <= 4'h3;
    wait_chk(120);
    chk("lock", 2'b01, lock);
    @(posedge i_clk);
    wide <= 1'b1;
    wait_chk(120);
    chk("lock", 2'b11, lock);
    $display("tolerance finished");
  endtask
  task automatic t_glitch();
    @(posedge i_clk);
    gap0 <= 4'h9;
    repeat (40) @(posedge i_clk);
    gap0 <= 4'h0;
    wait_chk(80);
    chk("lock", 2'b11, lock);
    chk("lost", 2'b00, lost);
    $display("glitch finished");
  endtask
  task automatic t_loss();
    @(posedge i_clk);
    gap0 <= 4'h9;
    wait_chk(160);
    chk("lock", 2'b10, lock);
    chk("lost", 2'b01, lost);
    chk("sum_irq", 2'b10, {summary, irq});
    @(posedge i_clk);
    mask <= 2'b01;
    wait_chk(4);
    chk("sum_irq", 2'b11, {summary, irq});
    @(posedge i_clk);
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    wait_chk(4);
    chk("sum_irq", 2'b11, {summary, irq});
    @(posedge i_clk);
    mask <= 2'b10;
    wait_chk(4);
    chk("sum_irq", 2'b10, {summary, irq});
    $display("loss finished");
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // ceiling well above the roughly 650 cycles the scenarios need
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      $display("unexpected cycle_limit expected 0 seen 1");
      complete_run();
    end
  end
  initial begin
    {err_total, n_tests, cycles} = '0;
    {i_rst_b, wide, rd, mask, gap0} = '0;
    gap1 = 4'h9;
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_acquire();
    t_tol();
    t_glitch();
    t_loss();
    complete_run();
  end
endmodule
